/* File: pin_function_controller.v */
// pin function and direction controller with avalon-mm register slave
//
// Notes on behaviour
// (R1) all handled pins start as port inputs
// (R2) port a bits 3,2: 1 output, 0 input
// (R3) port a direction resets zero, kept in sleep
// (R4) port e direction bit: 1 output, 0 input
// (R5) port e direction writable only at listed bits
// (R6) port e direction resets zero, kept in sleep
// (R7) function select resets zero, kept in sleep
// (R8) bit 14 routes pin 7 to timer ch2 b
// (R9) bit 12 routes pin 6 to timer ch2 a
// (R10) bit 10 routes pin 5 to timer ch1 b
// (R11) bit 8 routes pin 4 to timer ch1 a
// (R12) bit 4 routes pin 2 to timer ch0 c
// (R13) bit 0 routes pin 0 to timer ch0 a
// (R14) reserved function select bits read zero
// (R15) software writes zero to reserved bits
// (R16) timer owns pin direction and value when selected
`timescale 1ns/10ps
`include "pfc_consts.vh"
module pin_function_controller #(
    parameter PA_PINS = 2,
    parameter PE_WIDTH = 16,
    parameter TIMER_CH = 6
) (
    input wire clk,
    input wire rst_b,
    input wire [31:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire sleep_mode,
    input wire [PA_PINS-1:0] porta_data,
    input wire [PA_PINS-1:0] porta_pin_in,
    output reg [PA_PINS-1:0] porta_pin_out,
    output reg [PA_PINS-1:0] porta_pin_oe,
    output reg [PA_PINS-1:0] porta_pin_level,
    input wire [PE_WIDTH-1:0] pe_data,
    input wire [PE_WIDTH-1:0] pe_pin_in,
    output reg [PE_WIDTH-1:0] pe_pin_out,
    output reg [PE_WIDTH-1:0] pe_pin_oe,
    output reg [PE_WIDTH-1:0] pe_pin_level,
    input wire [TIMER_CH-1:0] timer_out,
    input wire [TIMER_CH-1:0] timer_oe,
    output reg [TIMER_CH-1:0] timer_in,
    output reg [15:0] port_a_dir_view,
    output reg [15:0] port_e_dir_view,
    output reg [15:0] port_e_func_view
);

    // structure: an avalon slave with one wait cycle in front of three
    // 16-bit registers, a per-pin routing chain for port e, plain direction
    // gating for port a, and two-flop synchronisers on every pad input;
    // all pad-facing outputs leave from flops so the enables never glitch

    // pin and field positions of the six multiplexed channels, highest first;
    // entry k of both tables belongs to timer index k, so timer_out[k],
    // timer_oe[k] and timer_in[k] all meet the same pin
    localparam [4*6-1:0] MUX_PIN = {
        4'd`PFC_PIN_TIMER_CH2_B, // index 5
        4'd`PFC_PIN_TIMER_CH2_A, // index 4
        4'd`PFC_PIN_TIMER_CH1_B,
        4'd`PFC_PIN_TIMER_CH1_A,
        4'd`PFC_PIN_TIMER_CH0_C,
        4'd`PFC_PIN_TIMER_CH0_A // index 0
    };
    localparam [4*6-1:0] MUX_FUNC = {
        4'd`PFC_POS_PE_PIN7_FUNC,
        4'd`PFC_POS_PE_PIN6_FUNC,
        4'd`PFC_POS_PE_PIN5_FUNC,
        4'd`PFC_POS_PE_PIN4_FUNC,
        4'd`PFC_POS_PE_PIN2_FUNC,
        4'd`PFC_POS_PE_PIN0_FUNC
    };

    // bus handshake states; two suffice, since no access ever needs more
    // than the single wait cycle
    localparam [0:0] ST_IDLE = 1'b0;
    localparam [0:0] ST_ACK = 1'b1;

    // software registers; positions that are not writable are never stored,
    // so they read back as zero without a separate read mask
    reg [15:0] port_a_direction_high_r;
    reg [15:0] port_a_direction_high_nxt;
    reg [15:0] port_e_direction_r;
    reg [15:0] port_e_direction_nxt;
    reg [15:0] port_e_function_select_r;
    reg [15:0] port_e_function_select_nxt;

    // bus slave state; readdata_nxt keeps the value loaded by the last access,
    // read or write, between accesses
    reg [0:0] bus_state_r;
    reg [0:0] bus_state_nxt;
    reg [31:0] readdata_nxt;

    // pin input synchronisers: first stage of each two-flop chain, read
    // by nothing but the second stage
    reg [PA_PINS-1:0] porta_meta_r;
    reg [PE_WIDTH-1:0] pe_meta_r;

    // decoded access
    wire bus_req;
    wire take;
    wire hit_pa;
    wire hit_pe_dir;
    wire hit_pe_func;
    wire [15:0] byte_mask;

    // combinational pin plan before the output flops, one cycle ahead of
    // what the pads see
    reg [PA_PINS-1:0] porta_out_nxt;
    reg [PA_PINS-1:0] porta_oe_nxt;
    wire [PE_WIDTH-1:0] pe_out_nxt;
    wire [PE_WIDTH-1:0] pe_oe_nxt;
    wire [TIMER_CH-1:0] timer_in_nxt;

    // per-pin port view, overridden below on multiplexed pins;
    // entry 0 is the plain port view, the last entry the final one
    wire [PE_WIDTH-1:0] pe_route_out [0:TIMER_CH];
    wire [PE_WIDTH-1:0] pe_route_oe [0:TIMER_CH];

    // a request is taken once, in idle; waitrequest drops in the ack cycle.
    // every access therefore costs exactly one wait cycle: the write lands
    // and the read data is loaded at the edge that ends the idle cycle, and
    // the master sees waitrequest low one cycle later. a master that holds
    // its request past the following edge starts a second access, so it
    // must drop read or write right after the edge where it sees it low
    assign bus_req = avs_read | avs_write;
    assign take = bus_req & (bus_state_r == ST_IDLE);
    assign avs_waitrequest = bus_req & (bus_state_r == ST_IDLE);

    // word-addressed decode on the full register index; any other address
    // hits nothing, so a write there is dropped and a read returns zero.
    // the full compare costs a few gates but keeps aliases off the map
    assign hit_pa = (avs_address == `PFC_IDX_PORT_A_DIRECTION_HIGH);
    assign hit_pe_dir = (avs_address == `PFC_IDX_PORT_E_DIRECTION);
    assign hit_pe_func = (avs_address == `PFC_IDX_PORT_E_FUNCTION_SELECT);

    // registers are 16 bits wide, so only the two low byte lanes matter;
    // lanes 3 and 2 and write data bits 31:16 are left unread on purpose
    assign byte_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // handshake sequencing: idle goes to ack on any request, ack always
    // back to idle; a request still held after ack is a fresh access
    always @* begin
        bus_state_nxt = bus_state_r;
        case (bus_state_r)
            ST_IDLE: begin
                if (bus_req) begin
                    bus_state_nxt = ST_ACK;
                end
            end
            ST_ACK: begin
                bus_state_nxt = ST_IDLE;
            end
            default: begin
                bus_state_nxt = ST_IDLE;
            end
        endcase
    end

    // register writes with byte lanes; unwritable bits are forced to zero.
    // clearing them on write rather than on read means the stored value
    // and the read-back value can never differ
    always @* begin
        port_a_direction_high_nxt = port_a_direction_high_r;
        port_e_direction_nxt = port_e_direction_r;
        port_e_function_select_nxt = port_e_function_select_r;
        if (take && avs_write) begin
            // port a keeps only its two direction bits
            if (hit_pa) begin
                port_a_direction_high_nxt = ((port_a_direction_high_r & ~byte_mask) |
                    (avs_writedata[15:0] & byte_mask)) &
                    `PFC_MASK_PORT_A_DIRECTION_HIGH;
            end
            // port e keeps its nine direction bits
            if (hit_pe_dir) begin
                port_e_direction_nxt = ((port_e_direction_r & ~byte_mask) |
                    (avs_writedata[15:0] & byte_mask)) &
                    `PFC_MASK_PORT_E_DIRECTION; // (R5)
            end
            if (hit_pe_func) begin
                // reserved bits are dropped even if software breaks the
                // zero-write convention, so they can never read back set
                port_e_function_select_nxt = ((port_e_function_select_r & ~byte_mask) |
                    (avs_writedata[15:0] & byte_mask)) &
                    `PFC_MASK_PORT_E_FUNCTION_SELECT; // (R14) (R15)
            end
        end
    end

    // read data, sampled in the take cycle and held through the ack cycle
    // and beyond, until the next access is taken
    always @* begin
        readdata_nxt = avs_readdata;
        if (take) begin
            // an unmapped read, or any write, answers zero
            readdata_nxt = 32'h00000000;
            if (avs_read) begin
                if (hit_pa) begin
                    readdata_nxt = {16'h0000, port_a_direction_high_r};
                end else if (hit_pe_dir) begin
                    readdata_nxt = {16'h0000, port_e_direction_r};
                end else if (hit_pe_func) begin
                    readdata_nxt = {16'h0000, port_e_function_select_r}; // (R14)
                end
            end
        end
    end

    // bus and register flops; sleep_mode has no path here, so the
    // registers simply hold while the chip sleeps. only a power-on
    // reset clears them; a user who expects sleep to restore defaults
    // must rewrite the registers after wake-up. sleep_mode is left
    // unread on purpose
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_state_r <= ST_IDLE;
            avs_readdata <= 32'h00000000;
            port_a_direction_high_r <= `PFC_RST_PORT_A_DIRECTION_HIGH; // (R3)
            port_e_direction_r <= `PFC_RST_PORT_E_DIRECTION; // (R6)
            port_e_function_select_r <= `PFC_RST_PORT_E_FUNCTION_SELECT; // (R7)
        end else begin
            bus_state_r <= bus_state_nxt;
            avs_readdata <= readdata_nxt;
            port_a_direction_high_r <= port_a_direction_high_nxt; // (R3)
            port_e_direction_r <= port_e_direction_nxt; // (R6)
            port_e_function_select_r <= port_e_function_select_nxt; // (R7)
        end
    end

    // port a: direction bits at 3 and 2 drive pins 19 and 18;
    // a pin set as input drives zero on its data line, so a later turn
    // to output starts from the data value and not from a stale one
    always @* begin
        porta_oe_nxt = {port_a_direction_high_r[`PFC_POS_PORTA_PIN19_DIR],
            port_a_direction_high_r[`PFC_POS_PORTA_PIN18_DIR]}; // (R2)
        porta_out_nxt = porta_data & porta_oe_nxt;
    end

    // non-multiplexed default view of every port e pin;
    // a pin set as input drives zero on its data line
    assign pe_route_out[0] = pe_data & port_e_direction_r;
    assign pe_route_oe[0] = port_e_direction_r; // (R4)

    // each multiplexed pin chains one override onto the port e view; every
    // stage rewrites a different bit, so the order of the stages is free
    genvar k;
    generate
        for (k = 0; k < TIMER_CH; k = k + 1) begin : g_mux
            wire sel;
            wire port_bit;
            wire drive;
            wire enable;
            wire level;
            // port data gated by direction, as on the unmultiplexed pins
            assign port_bit = pe_route_out[0][MUX_PIN[4*k +: 4]]; // (R4)
            // bits 14,12,10,8,4,0 steer pins 7,6,5,4,2,0 to the timer
            assign sel = port_e_function_select_r[MUX_FUNC[4*k +: 4]]; // (R8) (R9) (R10) (R11) (R12) (R13)
            pin_route u_route (
                .func_sel(sel),
                .port_dir(port_e_direction_r[MUX_PIN[4*k +: 4]]),
                .port_data(port_bit),
                .timer_drive(timer_out[k]),
                .timer_enable(timer_oe[k]),
                .pin_level(pe_pin_level[MUX_PIN[4*k +: 4]]),
                .pin_drive(drive),
                .pin_enable(enable),
                .timer_level(level)
            );
            // replace only this pin's bit in the running view
            assign pe_route_out[k+1] = (pe_route_out[k] &
                ~(16'h0001 << MUX_PIN[4*k +: 4])) |
                ({15'h0000, drive} << MUX_PIN[4*k +: 4]); // (R16)
            assign pe_route_oe[k+1] = (pe_route_oe[k] &
                ~(16'h0001 << MUX_PIN[4*k +: 4])) |
                ({15'h0000, enable} << MUX_PIN[4*k +: 4]); // (R16)
            // a channel not selected sees a steady zero, never a port pin
            assign timer_in_nxt[k] = level;
        end
    endgenerate

    // the last chain entry is what the pin flops load
    assign pe_out_nxt = pe_route_out[TIMER_CH];
    assign pe_oe_nxt = pe_route_oe[TIMER_CH];

    // pin inputs are asynchronous: two flops before anything reads them;
    // the first stage may go metastable, so only the second stage feeds
    // the level outputs and the timer capture path
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            porta_meta_r <= {PA_PINS{1'b0}};
            porta_pin_level <= {PA_PINS{1'b0}};
            pe_meta_r <= {PE_WIDTH{1'b0}};
            pe_pin_level <= {PE_WIDTH{1'b0}};
        end else begin
            porta_meta_r <= porta_pin_in;
            porta_pin_level <= porta_meta_r;
            pe_meta_r <= pe_pin_in;
            pe_pin_level <= pe_meta_r;
        end
    end

    // pin drivers come from flops; one cycle behind the register write,
    // traded for glitch-free enables at the pads. timer_in sits one flop
    // behind the synchronised level, three edges after the pad moves.
    // pins 12 to 14 are port-only, and the positions with no pin behind
    // them are forced off at the enable flop
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            porta_pin_out <= {PA_PINS{1'b0}};
            porta_pin_oe <= {PA_PINS{1'b0}}; // (R1)
            pe_pin_out <= {PE_WIDTH{1'b0}};
            pe_pin_oe <= {PE_WIDTH{1'b0}}; // (R1)
            timer_in <= {TIMER_CH{1'b0}};
        end else begin
            porta_pin_out <= porta_out_nxt;
            porta_pin_oe <= porta_oe_nxt; // (R2)
            pe_pin_out <= pe_out_nxt;
            pe_pin_oe <= pe_oe_nxt & `PFC_MASK_PORT_E_DIRECTION; // (R5)
            timer_in <= timer_in_nxt;
        end
    end

    // register views for the port data block's read-back choice; they
    // take the next-state value so they line up with the registers
    // themselves rather than trailing one cycle behind
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            port_a_dir_view <= 16'h0000;
            port_e_dir_view <= 16'h0000;
            port_e_func_view <= 16'h0000;
        end else begin
            port_a_dir_view <= port_a_direction_high_nxt;
            port_e_dir_view <= port_e_direction_nxt;
            port_e_func_view <= port_e_function_select_nxt;
        end
    end

endmodule

/* File: pfc_consts.vh */
// constants for the pin function and direction controller
`ifndef PFC_CONSTS_VH
`define PFC_CONSTS_VH

// register indices; byte address on the bus is four times the index
`define PFC_IDX_PORT_A_DIRECTION_HIGH 32'hffff8384
`define PFC_IDX_PORT_E_DIRECTION 32'hffff83b4
`define PFC_IDX_PORT_E_FUNCTION_SELECT 32'hffff83ba

// reset values
`define PFC_RST_PORT_A_DIRECTION_HIGH 16'h0000
`define PFC_RST_PORT_E_DIRECTION 16'h0000
`define PFC_RST_PORT_E_FUNCTION_SELECT 16'h0000

// writable bit masks
`define PFC_MASK_PORT_A_DIRECTION_HIGH 16'h000c
`define PFC_MASK_PORT_E_DIRECTION 16'h70f5
`define PFC_MASK_PORT_E_FUNCTION_SELECT 16'h5511

// port a direction field positions
`define PFC_POS_PORTA_PIN19_DIR 3
`define PFC_POS_PORTA_PIN18_DIR 2

// function select field positions
`define PFC_POS_PE_PIN7_FUNC 14
`define PFC_POS_PE_PIN6_FUNC 12
`define PFC_POS_PE_PIN5_FUNC 10
`define PFC_POS_PE_PIN4_FUNC 8
`define PFC_POS_PE_PIN2_FUNC 4
`define PFC_POS_PE_PIN0_FUNC 0

// port e pin numbers of the six multiplexed pins
`define PFC_PIN_TIMER_CH2_B 7
`define PFC_PIN_TIMER_CH2_A 6
`define PFC_PIN_TIMER_CH1_B 5
`define PFC_PIN_TIMER_CH1_A 4
`define PFC_PIN_TIMER_CH0_C 2
`define PFC_PIN_TIMER_CH0_A 0

// cycles from request to waitrequest low
`define PFC_BUS_WAIT_CYCLES 1

`endif

/* File: pin_route.v */
// one multiplexed port e pin: port function or timer channel
`timescale 1ns/10ps
module pin_route (
    input wire func_sel,
    input wire port_dir,
    input wire port_data,
    input wire timer_drive,
    input wire timer_enable,
    input wire pin_level,
    output wire pin_drive,
    output wire pin_enable,
    output wire timer_level
);

    // timer owns direction and value when selected, direction bit ignored
    assign pin_enable = func_sel ? timer_enable : port_dir; // (R16) (R4)
    assign pin_drive = func_sel ? timer_drive : port_data; // (R16)

    // the timer sees the pin only while it owns it, so a port pin
    // toggling cannot fire a spurious capture
    assign timer_level = func_sel & pin_level;

endmodule

/* File: pfc_checker_properties.sv */
// concurrent checks on the pin function controller ports
`timescale 1ns/10ps
module pfc_checker (
    input wire clk,
    input wire rst_b,
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    input wire [1:0] porta_data,
    input wire [1:0] porta_pin_oe,
    input wire [1:0] porta_pin_out,
    input wire [5:0] timer_oe,
    input wire [5:0] timer_in,
    input wire [15:0] pe_pin_oe,
    input wire [15:0] port_a_dir_view,
    input wire [15:0] port_e_dir_view,
    input wire [15:0] port_e_func_view
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // timer-owned pins spread onto port e positions
    wire [15:0] f = port_e_func_view;
    wire [5:0] fs = {f[14], f[12], f[10], f[8], f[4], f[0]};
    wire [15:0] ts = {8'h0, fs[5:2], 1'b0, fs[1], 1'b0, fs[0]};
    wire [15:0] toe = {8'h0, timer_oe[5:2], 1'b0, timer_oe[1], 1'b0, timer_oe[0]};
    wire [15:0] exp_oe = (port_e_dir_view & 16'h70f5 & ~ts) | (toe & ts);
    // pins lag a register change, so they are judged only once settled
    a_pe_oe_route: assert property (
        $stable(port_e_dir_view) && $stable(f) && $stable(timer_oe) |-> pe_pin_oe == exp_oe)
        else $error("port e enable off route");
    a_pa_oe_dir: assert property (
        $stable(port_a_dir_view) |-> porta_pin_oe == port_a_dir_view[3:2])
        else $error("port a enable wrong");
    a_pa_out_dir: assert property (
        $stable(port_a_dir_view) && $stable(porta_data)
        |-> porta_pin_out == (porta_data & port_a_dir_view[3:2]))
        else $error("port a drive wrong");
    a_pe_dir_mask: assert property (
        (port_e_dir_view & ~16'h70f5) == 16'h0) else $error("port e fixed bit set");
    a_func_resv: assert property (
        (f & ~16'h5511) == 16'h0) else $error("reserved select bit set");
    a_timer_gate: assert property (
        $stable(f) |-> (timer_in & ~fs) == 6'h0) else $error("timer sees port pin");
    a_reset_clear: assert property (
        $rose(rst_b) |-> {port_a_dir_view, port_e_dir_view, f, pe_pin_oe, porta_pin_oe} == 0)
        else $error("not clear after reset");
    a_regs_hold: assert property (
        !avs_write |=> $stable({port_a_dir_view, port_e_dir_view, f}))
        else $error("register moved without write");
    a_wait_once: assert property (
        $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("wait cycle count wrong");
    c_write: cover property (avs_write && !avs_waitrequest);
    c_read: cover property (avs_read && !avs_waitrequest);
    c_timer: cover property (|(pe_pin_oe & ts));
endmodule
bind pin_function_controller pfc_checker i_chk (.*);

/* File: tb.sv */
// self-checking bench for the pin function controller
`timescale 1ns/10ps
`include "pfc_consts.vh"
module tb;
    localparam [31:0] ra = `PFC_IDX_PORT_A_DIRECTION_HIGH;
    localparam [31:0] re = `PFC_IDX_PORT_E_DIRECTION;
    localparam [31:0] rf = `PFC_IDX_PORT_E_FUNCTION_SELECT;
    localparam [15:0] ma = `PFC_MASK_PORT_A_DIRECTION_HIGH;
    localparam [15:0] me = `PFC_MASK_PORT_E_DIRECTION;
    localparam [15:0] mf = `PFC_MASK_PORT_E_FUNCTION_SELECT;
    reg clk = 1'b0;
    reg rst_b = 1'b0;
    reg [31:0] avs_address = 32'h0;
    reg avs_read = 1'b0;
    reg avs_write = 1'b0;
    reg [31:0] avs_writedata = 32'h0;
    reg [3:0] avs_byteenable = 4'hf;
    reg sleep_mode = 1'b0;
    reg [1:0] porta_data = 2'h0;
    reg [1:0] porta_pin_in = 2'h0;
    reg [15:0] pe_data = 16'h0;
    reg [15:0] pe_pin_in = 16'h0;
    reg [5:0] timer_out = 6'h0;
    reg [5:0] timer_oe = 6'h0;
    wire [31:0] avs_readdata;
    wire avs_waitrequest;
    wire [1:0] porta_pin_out, porta_pin_oe, porta_pin_level;
    wire [15:0] pe_pin_out, pe_pin_oe, pe_pin_level;
    wire [5:0] timer_in;
    wire [15:0] port_a_dir_view, port_e_dir_view, port_e_func_view;
    int err_count = 0;
    int num_checks = 0;
    logic [15:0] expq [$];
    reg [15:0] a, d, f;
    integer i;
    pin_function_controller i_dut (.*);
    always #12.5 clk = ~clk;
    task report_and_stop;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task check(input [31:0] seen, input [31:0] want);
        num_checks++;
        if (seen !== want) begin
            err_count++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    // one avalon access; a read notes its expected value for the monitor
    task bus(input w, input [31:0] adr, input [15:0] dat, input [3:0] be, input [15:0] want);
        int n;
        @(posedge clk);
        avs_address <= adr;
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= ($urandom << 16) | dat; // upper half must be ignored
        avs_byteenable <= be;
        if (!w) expq.push_back(want);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            err_count++;
            report_and_stop;
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // read data is taken only at the edge where waitrequest is low
    always @(posedge clk) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            check(avs_readdata, {16'h0, expq.pop_front()});
        end
    end
    // reset, then every register reads zero and no pin drives
    task do_reset;
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        bus(1'b0, ra, 0, 4'hf, 16'h0);
        bus(1'b0, re, 0, 4'hf, 16'h0);
        bus(1'b0, rf, 0, 4'hf, 16'h0);
        check({pe_pin_oe, porta_pin_oe}, 0);
    endtask
    // settled pins against the written registers and the timer inputs
    task pins;
        reg [15:0] ts, toe, tout;
        reg [5:0] fs;
        ts = {8'h0, f[14], f[12], f[10], f[8], 1'b0, f[4], 1'b0, f[0]};
        fs = {f[14], f[12], f[10], f[8], f[4], f[0]};
        toe = {8'h0, timer_oe[5:2], 1'b0, timer_oe[1], 1'b0, timer_oe[0]};
        tout = {8'h0, timer_out[5:2], 1'b0, timer_out[1], 1'b0, timer_out[0]};
        repeat (5) @(posedge clk);
        check(pe_pin_oe, (d & me & ~ts) | (toe & ts));
        check(pe_pin_out, (pe_data & d & me & ~ts) | (tout & ts));
        check(porta_pin_oe, a[3:2]);
        check(porta_pin_out, porta_data & a[3:2]);
        check({port_a_dir_view, port_e_dir_view}, {a & ma, d & me});
        check(port_e_func_view, f);
        check(timer_in, {pe_pin_in[7:4], pe_pin_in[2], pe_pin_in[0]} & fs);
    endtask
    initial begin
        i = $urandom(32'ha810);
        do_reset;
        // all ones keep only the writable bits
        bus(1'b1, ra, 16'hffff, 4'hf, 0);
        bus(1'b0, ra, 0, 4'hf, ma);
        bus(1'b1, re, 16'hffff, 4'hf, 0);
        bus(1'b0, re, 0, 4'hf, me);
        bus(1'b1, rf, 16'hffff, 4'hf, 0);
        bus(1'b1, rf, 16'h0000, 4'h2, 0);
        bus(1'b0, rf, 0, 4'hf, mf & 16'h00ff);
        bus(1'b1, ra + 32'h1, 16'hffff, 4'hf, 0);
        bus(1'b0, ra + 32'h1, 0, 4'hf, 16'h0);
        for (i = 0; i < 30; i++) begin
            a = $urandom;
            d = $urandom;
            f = $urandom & mf;
            pe_data <= 16'($urandom);
            pe_pin_in <= 16'($urandom);
            porta_data <= 2'($urandom);
            porta_pin_in <= 2'($urandom);
            timer_out <= 6'($urandom);
            timer_oe <= 6'($urandom);
            sleep_mode <= 1'($urandom);
            bus(1'b1, ra, a, 4'hf, 0);
            bus(1'b1, re, d, 4'hf, 0);
            bus(1'b1, rf, f, 4'hf, 0);
            pins;
            check({porta_pin_level, pe_pin_level}, {porta_pin_in, pe_pin_in});
            bus(1'b0, ra, 0, 4'hf, a & ma);
            bus(1'b0, re, 0, 4'hf, d & me);
            bus(1'b0, rf, 0, 4'hf, f);
        end
        do_reset;
        report_and_stop;
    end
endmodule
